// File: src/wtu_watchdog.sv
// watchdog timeout unit: counter, key control and AXI4-Lite register slave
`timescale 1ns/1ns
// Summary of operation
// RQ1 - 22-stage up-counter advancing at half system clock
// RQ2 - period code selects tap 15, 17, 19, 21
// RQ3 - overflow while enabled raises nonmaskable interrupt
// RQ4 - optional reset pulse lasting 22 to 29 states
// RQ5 - any reset restores system clock divide-by-eight
// RQ6 - period field resets to shortest tap
// RQ7 - enable bit resets to one, watchdog active
// RQ8 - disable needs enable cleared, then key B1
// RQ9 - setting enable bit alone re-enables watchdog
// RQ10 - reset option clears on reset, interrupt only
// RQ11 - key 4E clears counter, counting resumes
// RQ12 - key B1 also clears the counter
// RQ13 - counting starts right after reset release
// RQ14 - stop modes clear and halt the counter
// RQ15 - counting continues during external bus grant
// RQ16 - idle-run bit chooses counting in idle
// RQ17 - disabled watchdog holds zero, no events
module wtu_watchdog
    import wtu_pkg::*;
(
    input  wire logic                      ref_clk,        // 50 MHz reference clock
    input  wire logic                      reset_n,        // async reset, active low
    input  wire logic                      ce,             // clock enable, freezes state
    input  wire logic                      stopMode,       // deep or full stop standby
    input  wire logic                      idleMode,       // idle standby
    output logic                           watchdogInterrupt, // nonmaskable request pulse
    output logic                           systemReset,    // internal reset, active high
    output logic [GEAR_WIDTH-1:0]          clockGear,      // system clock divider code
    input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_awaddr,   // write address
    input  wire logic                      s_axi_awvalid,  // write address valid
    output logic                           s_axi_awready,  // write address ready
    input  wire logic [AXI_DATA_WIDTH-1:0] s_axi_wdata,    // write data
    input  wire logic [3:0]                s_axi_wstrb,    // write byte strobes
    input  wire logic                      s_axi_wvalid,   // write data valid
    output logic                           s_axi_wready,   // write data ready
    output logic [1:0]                     s_axi_bresp,    // write response
    output logic                           s_axi_bvalid,   // write response valid
    input  wire logic                      s_axi_bready,   // write response ready
    input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_araddr,   // read address
    input  wire logic                      s_axi_arvalid,  // read address valid
    output logic                           s_axi_arready,  // read address ready
    output logic [AXI_DATA_WIDTH-1:0]      s_axi_rdata,    // read data
    output logic [1:0]                     s_axi_rresp,    // read response
    output logic                           s_axi_rvalid,   // read data valid
    input  wire logic                      s_axi_rready    // read data ready
);
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wtu_wr_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } wtu_rd_e;

    // reset release through two flops
    logic rstMeta_q;
    logic rstSync_q;
    logic rstN;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    assign rstN = rstSync_q;

    // write channel state
    wtu_wr_e                   wrState_q;
    wtu_wr_e                   wrState_d;
    logic                      awHeld_q;
    logic                      wHeld_q;
    logic [3:0]                awOff_q;
    logic                      awMapped_q;
    logic [REG_WIDTH-1:0]      wByte_q;
    logic                      wLane_q;
    logic [1:0]                bresp_q;
    logic                      awTaken;
    logic                      wTaken;
    logic                      writeCommit;
    logic                      bTaken;

    // read channel state
    wtu_rd_e                   rdState_q;
    wtu_rd_e                   rdState_d;
    logic [AXI_DATA_WIDTH-1:0] rdata_q;
    logic [1:0]                rresp_q;
    logic                      arTaken;
    logic                      rTaken;
    logic [3:0]                arOff;
    logic                      arMapped;
    logic [AXI_DATA_WIDTH-1:0] readWord;

    // control registers
    logic [REG_WIDTH-1:0]      mode_q;
    logic [REG_WIDTH-1:0]      mode_d;
    logic [GEAR_WIDTH-1:0]     gear_q;
    logic [GEAR_WIDTH-1:0]     gear_d;
    logic                      active_q;
    logic                      active_d;
    logic [CNT_WIDTH-1:0]      count_q;
    logic [CNT_WIDTH-1:0]      count_d;
    logic                      irq_q;

    // decoded write effects
    logic                      lowLane;
    logic                      modeWrite;
    logic                      keyWrite;
    logic                      gearWrite;
    logic                      keyClear;
    logic                      keyDisable;
    logic [REG_WIDTH-1:0]      modeWritten;

    // counting
    logic                      fsysTick;
    logic                      wdtTick;
    logic                      enableBit;
    logic                      idleRun;
    logic                      resetOnTimeout;
    logic [1:0]                periodSel;
    logic                      standbyHalt;
    logic                      running;
    logic                      overflow;
    logic                      resetTrigger;
    logic                      resetActive;

    function automatic logic wtu_mapped(input logic [AXI_ADDR_WIDTH-1:0] addr);
        wtu_mapped = (addr[AXI_ADDR_WIDTH-1:4] == '0) && (addr[1:0] == 2'h0);
    endfunction

    // write channel
    assign s_axi_awready = ce && (wrState_q == WR_IDLE) && !awHeld_q;
    assign s_axi_wready  = ce && (wrState_q == WR_IDLE) && !wHeld_q;
    assign s_axi_bvalid  = (wrState_q == WR_RESP);
    assign s_axi_bresp   = bresp_q;

    assign awTaken     = s_axi_awvalid && s_axi_awready;
    assign wTaken      = s_axi_wvalid && s_axi_wready;
    assign writeCommit = ce && (wrState_q == WR_IDLE) && awHeld_q && wHeld_q;
    assign bTaken      = ce && s_axi_bvalid && s_axi_bready;

    assign wrState_d = writeCommit ? WR_RESP :
                       bTaken      ? WR_IDLE : wrState_q;

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            awHeld_q   <= 1'b0;
            awOff_q    <= 4'h0;
            awMapped_q <= 1'b0;
        end else if (ce) begin
            if (awTaken) begin
                awHeld_q   <= 1'b1;
                awOff_q    <= s_axi_awaddr[3:0];
                awMapped_q <= wtu_mapped(s_axi_awaddr);
            end else if (writeCommit) begin
                awHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            wHeld_q <= 1'b0;
            wByte_q <= 8'h00;
            wLane_q <= 1'b0;
        end else if (ce) begin
            if (wTaken) begin
                wHeld_q <= 1'b1;
                wByte_q <= s_axi_wdata[REG_WIDTH-1:0];
                wLane_q <= s_axi_wstrb[0];
            end else if (writeCommit) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    // status is read-only: writes get an error
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            wrState_q <= WR_IDLE;
            bresp_q   <= AXI_RESP_OKAY;
        end else if (ce) begin
            wrState_q <= wrState_d;
            if (writeCommit) begin
                bresp_q <= (awMapped_q && awOff_q != STATUS_OFFSET) ?
                           AXI_RESP_OKAY : AXI_RESP_SLVERR;
            end
        end
    end

    // 8-bit registers live in byte lane 0
    assign lowLane    = writeCommit && awMapped_q && wLane_q;
    assign modeWrite  = lowLane && (awOff_q == MODE_OFFSET);
    assign keyWrite   = lowLane && (awOff_q == KEY_OFFSET);
    assign gearWrite  = lowLane && (awOff_q == GEAR_OFFSET);
    assign keyClear   = keyWrite && (wByte_q == KEY_CLEAR);
    assign keyDisable = keyWrite && (wByte_q == KEY_DISABLE);
    assign modeWritten = wByte_q & MODE_WRITE_MASK;

    // read channel
    assign s_axi_arready = ce && (rdState_q == RD_IDLE);
    assign s_axi_rvalid  = (rdState_q == RD_DATA);
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign arTaken  = s_axi_arvalid && s_axi_arready;
    assign rTaken   = ce && s_axi_rvalid && s_axi_rready;
    assign arOff    = s_axi_araddr[3:0];
    assign arMapped = wtu_mapped(s_axi_araddr);

    // key control is write-only and reads back as zero
    assign readWord =
        !arMapped                ? 32'h0 :
        (arOff == MODE_OFFSET)   ? {24'h0, mode_q} :
        (arOff == GEAR_OFFSET)   ? {30'h0, gear_q} :
        (arOff == STATUS_OFFSET) ? {6'h00, resetActive, active_q, 2'h0, count_q} :
                                   32'h0;

    assign rdState_d = arTaken ? RD_DATA :
                       rTaken  ? RD_IDLE : rdState_q;

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            rdState_q <= RD_IDLE;
            rdata_q   <= 32'h0;
            rresp_q   <= AXI_RESP_OKAY;
        end else if (ce) begin
            rdState_q <= rdState_d;
            if (arTaken) begin
                rdata_q <= readWord;
                rresp_q <= arMapped ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
            end
        end
    end

    // watchdog control
    assign enableBit      = mode_q[MODE_ENABLE_BIT];
    assign idleRun        = mode_q[MODE_IDLE_RUN_BIT];
    assign resetOnTimeout = mode_q[MODE_RESET_BIT];
    assign periodSel      = mode_q[MODE_PERIOD_LSB+1:MODE_PERIOD_LSB];

    // own reset pulse restores mode defaults
    assign mode_d = resetActive ? MODE_RESET_VALUE : // see RQ6, RQ7, RQ10
                    modeWrite   ? modeWritten : mode_q;

    // own reset also restores slowest gear
    assign gear_d = resetActive ? GEAR_RESET_VALUE : // see RQ5
                    gearWrite   ? wByte_q[GEAR_WIDTH-1:0] : gear_q;

    // the key only disarms once the enable bit is already low, so a
    // runaway program needs two separate correct stores to stop it
    assign active_d =
        resetActive ? 1'b1 :
        (modeWrite && modeWritten[MODE_ENABLE_BIT]) ? 1'b1 : // see RQ9
        (keyDisable && !enableBit) ? 1'b0 : active_q; // see RQ8

    // bus grant is not an input: counting ignores it on purpose
    assign standbyHalt = stopMode || (idleMode && !idleRun); // see RQ14, RQ16
    assign running     = active_q && !standbyHalt && !resetActive; // see RQ15, RQ17

    assign overflow = wdtTick && running && // see RQ3
                      ((count_q & wtu_tap_mask(periodSel)) ==
                       wtu_tap_mask(periodSel)); // see RQ2

    assign resetTrigger = overflow && resetOnTimeout; // see RQ4, RQ10

    // clear keys win over an increment in the same cycle
    assign count_d =
        (!active_q || stopMode || resetActive) ? '0 : // see RQ14, RQ17
        (keyClear || keyDisable)               ? '0 : // see RQ11, RQ12
        (wdtTick && running)                   ? count_q + 1'b1 : // see RQ1, RQ13
                                                 count_q;

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            mode_q   <= MODE_RESET_VALUE; // see RQ6, RQ7, RQ10
            gear_q   <= GEAR_RESET_VALUE; // see RQ5
            active_q <= 1'b1; // see RQ7, RQ13
            count_q  <= '0;
            irq_q    <= 1'b0;
        end else if (ce) begin
            mode_q   <= mode_d;
            gear_q   <= gear_d;
            active_q <= active_d;
            count_q  <= count_d;
            irq_q    <= overflow; // see RQ3
        end
    end

    assign watchdogInterrupt = irq_q;
    assign clockGear         = gear_q;
    assign systemReset       = resetActive;

    wtu_gear_tick u_gear_tick (
        .clk      (ref_clk),
        .rstN     (rstN),
        .ce       (ce),
        .gear     (gear_q),
        .fsysTick (fsysTick),
        .wdtTick  (wdtTick)
    );

    // length counts system states, not ref cycles
    wtu_reset_pulse #(
        .STATES (RESET_STATES)
    ) u_reset_pulse (
        .clk         (ref_clk),
        .rstN        (rstN),
        .ce          (ce),
        .trigger     (resetTrigger),
        .fsysTick    (fsysTick),
        .resetActive (resetActive)
    );
endmodule

// File: src/wtu_pkg.sv
// constants, register map and field layout of the watchdog timeout unit
package wtu_pkg;
    localparam int unsigned CNT_WIDTH       = 22;
    localparam int unsigned AXI_ADDR_WIDTH  = 12;
    localparam int unsigned AXI_DATA_WIDTH  = 32;
    localparam int unsigned REG_WIDTH       = 8;

    localparam logic [3:0] MODE_OFFSET      = 4'h0;
    localparam logic [3:0] KEY_OFFSET       = 4'h4;
    localparam logic [3:0] GEAR_OFFSET      = 4'h8;
    localparam logic [3:0] STATUS_OFFSET    = 4'hC;

    localparam int unsigned MODE_ENABLE_BIT   = 7;
    localparam int unsigned MODE_PERIOD_LSB   = 5;
    localparam int unsigned MODE_IDLE_RUN_BIT = 4;
    localparam int unsigned MODE_RESET_BIT    = 1;
    localparam logic [7:0]  MODE_RESET_VALUE  = 8'h80;
    localparam logic [7:0]  MODE_WRITE_MASK   = 8'hF2;

    localparam logic [7:0]  KEY_CLEAR         = 8'h4E;
    localparam logic [7:0]  KEY_DISABLE       = 8'hB1;

    localparam int unsigned GEAR_WIDTH        = 2;
    localparam logic [1:0]  GEAR_RESET_VALUE  = 2'h3;

    localparam int unsigned TAP_CODE0         = 15;
    localparam int unsigned TAP_CODE1         = 17;
    localparam int unsigned TAP_CODE2         = 19;
    localparam int unsigned TAP_CODE3         = 21;

    localparam int unsigned RESET_STATES      = 24;

    localparam int unsigned STATUS_ACTIVE_BIT = 24;
    localparam int unsigned STATUS_RESET_BIT  = 25;

    localparam logic [1:0]  AXI_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  AXI_RESP_SLVERR   = 2'h2;

    // low bits that must all be ones for the chosen tap to overflow
    function automatic logic [CNT_WIDTH-1:0] wtu_tap_mask(input logic [1:0] period);
        int unsigned tap;
        case (period)
            2'h0:    tap = TAP_CODE0;
            2'h1:    tap = TAP_CODE1;
            2'h2:    tap = TAP_CODE2;
            default: tap = TAP_CODE3;
        endcase
        wtu_tap_mask = ~({CNT_WIDTH{1'b1}} << tap);
    endfunction
endpackage

// File: src/wtu_gear_tick.sv
// clock gear divider: system tick and halved watchdog tick
`timescale 1ns/1ns
module wtu_gear_tick
    import wtu_pkg::*;
(
    input  wire logic                  clk,       // reference clock
    input  wire logic                  rstN,      // synchronised reset
    input  wire logic                  ce,        // clock enable
    input  wire logic [GEAR_WIDTH-1:0] gear,      // divide by 1,2,4,8
    output logic                       fsysTick,  // one pulse per system clock
    output logic                       wdtTick    // every second system tick
);
    logic [2:0] divCnt_q;
    logic [2:0] divLast;
    logic       half_q;

    assign divLast  = 3'((4'h1 << gear) - 4'h1);
    assign fsysTick = ce && (divCnt_q >= divLast);
    assign wdtTick  = fsysTick && half_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            divCnt_q <= 3'h0;
            half_q   <= 1'b0;
        end else if (ce) begin
            divCnt_q <= fsysTick ? 3'h0 : divCnt_q + 3'h1;
            if (fsysTick) begin
                half_q <= !half_q;
            end
        end
    end
endmodule

// File: src/wtu_reset_pulse.sv
// stretches a time-out into a fixed-length system reset
`timescale 1ns/1ns
module wtu_reset_pulse
    import wtu_pkg::*;
#(
    parameter int unsigned STATES = RESET_STATES
)(
    input  wire logic clk,          // reference clock
    input  wire logic rstN,         // synchronised reset
    input  wire logic ce,           // clock enable
    input  wire logic trigger,      // time-out with reset enabled
    input  wire logic fsysTick,     // one state
    output logic      resetActive   // registered reset level
);
    localparam int unsigned CW = $clog2(STATES + 1);
    localparam logic [CW-1:0] LOAD = CW'(STATES);

    logic [CW-1:0] left_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            left_q      <= '0;
            resetActive <= 1'b0;
        end else if (ce) begin
            if (trigger && !resetActive) begin
                left_q      <= LOAD;
                resetActive <= 1'b1;
            end else if (resetActive && fsysTick) begin
                left_q      <= left_q - 1'b1;
                resetActive <= (left_q != {{(CW-1){1'b0}}, 1'b1});
            end
        end
    end
endmodule

// File: tb/wtu_watchdog_asserts.sv
// concurrent checks on the ports of the watchdog timeout unit
`timescale 1ns/1ns
module wtu_watchdog_asserts
    import wtu_pkg::*;
(
    input wire logic                  ref_clk,           // reference clock
    input wire logic                  reset_n,           // reset, active low
    input wire logic                  stopMode,          // stop standby
    input wire logic                  watchdogInterrupt, // nonmaskable pulse
    input wire logic                  systemReset,       // internal reset level
    input wire logic [GEAR_WIDTH-1:0] clockGear,         // gear code
    input wire logic                  s_axi_awvalid,     // aw valid
    input wire logic                  s_axi_awready,     // aw ready
    input wire logic                  s_axi_wvalid,      // w valid
    input wire logic                  s_axi_wready,      // w ready
    input wire logic                  s_axi_bvalid,      // b valid
    input wire logic                  s_axi_arvalid,     // ar valid
    input wire logic                  s_axi_arready,     // ar ready
    input wire logic                  s_axi_rvalid,      // r valid
    input wire logic [1:0]            s_axi_rresp        // r response
);
    logic [16:0] gapCnt_q;
    logic [8:0]  rstLen_q;

    // saturates so a long quiet spell never wraps
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gapCnt_q <= 17'h0;
            rstLen_q <= 9'h0;
        end else begin
            gapCnt_q <= watchdogInterrupt ? 17'h0 : gapCnt_q + {16'h0, ~&gapCnt_q};
            rstLen_q <= systemReset ? rstLen_q + 9'h1 : 9'h0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_INT_PULSE: assert property (watchdogInterrupt |=> !watchdogInterrupt)
        else $error("interrupt too long");
    AST_INT_GAP: assert property (watchdogInterrupt |-> gapCnt_q > 17'd65500)
        else $error("interrupt too soon");
    AST_RST_CAUSE: assert property ($rose(systemReset) |-> watchdogInterrupt || gapCnt_q < 17'd4)
        else $error("reset without time-out");
    AST_RST_LEN: assert property ($fell(systemReset) |-> rstLen_q >= 9'd176 && rstLen_q <= 9'd232)
        else $error("reset length wrong");
    AST_RST_GEAR: assert property ($fell(systemReset) |-> clockGear == 2'h3)
        else $error("gear wrong after reset");
    AST_STOP_QUIET: assert property (stopMode [*3] |-> !watchdogInterrupt)
        else $error("interrupt in stop");
    AST_B_LATENCY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");

    COV_INT: cover property (watchdogInterrupt);
    COV_RST: cover property ($rose(systemReset));
    COV_STOP: cover property (stopMode [*3]);
    COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// File: tb/wtu_cpu_model.sv
// processor side: takes nonmaskable requests and times the system reset
`timescale 1ns/1ns
module wtu_cpu_model (
    input  wire logic clk,         // reference clock
    input  wire logic rstN,        // bench reset, active low
    input  wire logic nmi,         // nonmaskable request pulse
    input  wire logic sysReset,    // internal reset level
    output int        nmiCount,    // requests taken
    output int        resetCycles  // length of the last reset
);
    int runLen;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            nmiCount    <= 0;
            resetCycles <= 0;
            runLen      <= 0;
        end else begin
            if (nmi) nmiCount <= nmiCount + 1;
            if (sysReset) begin
                runLen <= runLen + 1;
            end else if (runLen != 0) begin
                resetCycles <= runLen;
                runLen      <= 0;
            end
        end
    end
endmodule

// File: tb/tb.sv
// self-checking bench for the watchdog timeout unit
`timescale 1ns/1ns
module tb;
    import wtu_pkg::*;
    localparam logic [11:0] AMODE = {8'h0, MODE_OFFSET};
    localparam logic [11:0] AKEY  = {8'h0, KEY_OFFSET};
    localparam logic [11:0] AGEAR = {8'h0, GEAR_OFFSET};
    localparam logic [11:0] ASTAT = {8'h0, STATUS_OFFSET};
    logic        refClk, resetN, stopMode, idleMode;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire  logic  watchdogInterrupt, systemReset, s_axi_awready, s_axi_wready;
    wire  logic  s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  logic [1:0]  clockGear, s_axi_bresp, s_axi_rresp;
    wire  logic [31:0] s_axi_rdata;
    int          nmiCount, resetCycles, failCount, compares, cycles;
    logic [1:0]  rs;

    wtu_watchdog dut (.ref_clk(refClk), .reset_n(resetN), .ce(1'b1), .stopMode, .idleMode,
        .watchdogInterrupt, .systemReset, .clockGear, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    wtu_cpu_model cpu (.clk(refClk), .rstN(resetN), .nmi(watchdogInterrupt),
        .sysReset(systemReset), .nmiCount, .resetCycles);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failCount++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit aw = 1, w = 1, b = 1;
        int n = 0;
        @(posedge refClk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (b && n < 200) begin
            @(posedge refClk);
            n++;
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
            if (s_axi_bvalid) begin
                b = 0;
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
        if (b) failCount++;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        bit ar = 1, r = 1;
        int n = 0;
        @(posedge refClk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (r && n < 200) begin
            @(posedge refClk);
            n++;
            ar = ar && !s_axi_arready;
            s_axi_arvalid <= ar;
            if (s_axi_rvalid) begin
                r = 0;
                d = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
        if (r) failCount++;
    endtask

    task automatic pair(input int gap, output logic [31:0] a, output logic [31:0] b);
        rd(ASTAT, a);
        repeat (gap) @(posedge refClk);
        rd(ASTAT, b);
    endtask

    task automatic rate(input int div);
        logic [31:0] a, b;
        time t;
        int e, d;
        rd(ASTAT, a);
        t = $time;
        repeat (160) @(posedge refClk);
        rd(ASTAT, b);
        e = int'(($time - t) / 20) / div;
        d = int'(b[21:0] - a[21:0]);
        chk(32'(d >= e - 1 && d <= e + 1), 32'h1);
    endtask

    task automatic testReset();
        logic [31:0] d;
        rd(AMODE, d);
        chk(d, 32'h80);
        rd(AGEAR, d);
        chk(d, 32'h3);
        chk({30'h0, clockGear}, 32'h3);
        rd(12'h010, d);
        chk(32'(rs), 32'(AXI_RESP_SLVERR));
        rate(16);
        $display("reset values done");
    endtask

    task automatic testDisable();
        logic [31:0] d;
        wr(AGEAR, 32'h0);
        chk({30'h0, clockGear}, 32'h0);
        rate(2);
        wr(AKEY, 32'hB1);
        rd(ASTAT, d);
        chk(32'(d[24]), 32'h1);
        wr(AMODE, 32'h0);
        rd(ASTAT, d);
        chk(32'(d[24]), 32'h1);
        wr(AKEY, 32'hB1);
        repeat (20) @(posedge refClk);
        rd(ASTAT, d);
        chk(d & 32'h013F_FFFF, 32'h0);
        wr(AMODE, 32'h80);
        repeat (20) @(posedge refClk);
        rd(ASTAT, d);
        chk(32'(d[24] && d[21:0] != 22'h0), 32'h1);
        $display("disable and enable done");
    endtask

    task automatic testClear();
        logic [31:0] d;
        repeat (100) @(posedge refClk);
        wr(AKEY, 32'h55);
        rd(ASTAT, d);
        chk(32'(d[21:0] > 22'd40), 32'h1);
        wr(AKEY, 32'h4E);
        rd(ASTAT, d);
        chk(32'(d[21:0] != 22'h0 && d[21:0] < 22'd8), 32'h1);
        wr(ASTAT, 32'h0);
        chk(32'(rs), 32'(AXI_RESP_SLVERR));
        $display("counter clear done");
    endtask

    task automatic testStandby();
        logic [31:0] a, b;
        idleMode <= 1'b1;
        pair(40, a, b);
        chk({10'h0, b[21:0]}, {10'h0, a[21:0]});
        wr(AMODE, 32'h90);
        pair(40, a, b);
        chk(32'(b[21:0] > a[21:0]), 32'h1);
        idleMode <= 1'b0;
        stopMode <= 1'b1;
        pair(40, a, b);
        chk({10'h0, a[21:0] | b[21:0]}, 32'h0);
        stopMode <= 1'b0;
        wr(AMODE, 32'h80);
        $display("standby done");
    endtask

    task automatic testTimeout();
        logic [31:0] d;
        int c0, n;
        wr(AMODE, 32'h82);
        wr(AKEY, 32'h4E);
        c0 = nmiCount;
        n = 0;
        while (nmiCount == c0 && n < 70000) begin
            @(posedge refClk);
            n++;
        end
        // tap 15, gear 0: one count per two cycles
        chk(32'(n >= (2 << 15) - 16 && n <= (2 << 15) + 14), 32'h1);
        n = 0;
        while (resetCycles == 0 && n < 400) begin
            @(posedge refClk);
            n++;
        end
        chk(32'(resetCycles >= 22 * 8 && resetCycles <= 29 * 8), 32'h1);
        chk(32'(nmiCount), 32'(c0 + 1));
        chk({30'h0, clockGear}, 32'h3);
        rd(AMODE, d);
        chk(d, 32'h80);
        $display("time-out done");
    endtask

    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        refClk = 1'b0;
        forever #10 refClk = ~refClk;
    end

    // run takes about 70000 cycles, mostly the time-out
    always @(posedge refClk) begin
        cycles++;
        if (cycles == 90000) begin
            failCount++;
            printVerdict();
        end
    end

    initial begin
        {resetN, stopMode, idleMode} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        repeat (2) @(posedge refClk);
        resetN <= 1'b1;
        repeat (3) @(posedge refClk);
        testReset();
        testDisable();
        testClear();
        testStandby();
        testTimeout();
        printVerdict();
    end
endmodule

bind wtu_watchdog wtu_watchdog_asserts chkr (
    .ref_clk, .reset_n, .stopMode, .watchdogInterrupt, .systemReset, .clockGear,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp
);
